// ---- core/pipe_pkg.sv ----
package pipe_pkg;
  // Register indices; the byte address on the bus is the index times four
  localparam logic [11:0] PORTA_HIGH_IDX = 12'hfc4;
  localparam logic [11:0] PORTA_LOW_IDX = 12'hfc5;
  localparam logic [11:0] PORTC_HIGH_IDX = 12'hfc7;
  localparam logic [11:0] PORTC_LOW_IDX = 12'hfc8;
  localparam logic [11:0] EDGE_POL_IDX = 12'hfcd;
  localparam logic [11:0] SHARED_SEL_IDX = 12'hfce;
  // Request, control, status and mask register indices
  localparam logic [11:0] PORTA_REQ_IDX = 12'hfc3;
  localparam logic [11:0] PORTC_REQ_IDX = 12'hfc6;
  localparam logic [11:0] GLOBAL_CTL_IDX = 12'hfcf;
  localparam logic [11:0] IRQ_STATUS_IDX = 12'hfd0;
  localparam logic [11:0] IRQ_MASK_IDX = 12'hfd1;
  // Field positions
  localparam int SHARED_SEL_BIT = 6;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PORTC_WIDTH = 4;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // Priority codes
  typedef enum logic [1:0]
  {
    PIPE_DISABLED = 2'b00,
    PIPE_LEVEL1 = 2'b01,
    PIPE_LEVEL2 = 2'b10,
    PIPE_LEVEL3 = 2'b11
  } pipe_level_type;
endpackage

// ---- core/pipe_top.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - Port A priority from high/low bit pair
// - Port C uses same two-bit priority code
// - Port A high enable register, reset zero
// - Port A low enable register, reset zero
// - Port C high enable, bits 3..0 only
// - Port C low enable, bits 3..0 only
// - Edge polarity: zero falling, one rising
// - Bit 6 selects pin 6 or comparator
// - Source switch edge counts as request
// - Pending bits set regardless of enables
// - Forward requests only with global enable
module pipe_top
#(
  parameter int PORTA_WIDTH = 8
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [PORTA_WIDTH-1:0] portaPins,
  input wire logic [pipe_pkg::PORTC_WIDTH-1:0] portcPins,
  input wire logic comparatorOut,
  output logic cpuReq,
  output logic [3:0] cpuReqId,
  output logic [1:0] cpuReqLevel,
  output logic irqOut
);
  import pipe_pkg::*;

  // Programmed registers
  logic [7:0] portaHigh_q; // Port A high enable bits
  logic [7:0] portaLow_q; // Port A low enable bits
  logic [3:0] portcHigh_q; // Port C high enable bits
  logic [3:0] portcLow_q; // Port C low enable bits
  logic [7:0] edgePol_q; // Edge polarity per pin
  logic [7:0] sharedSel_q; // Shared source select
  logic [7:0] portaReq_q; // Port A pending requests
  logic [3:0] portcReq_q; // Port C pending requests
  logic globalEn_q; // Global interrupt enable
  logic [1:0] status_q; // Sticky event flags
  logic [1:0] mask_q; // Event mask
  // Edge detection history
  logic [7:0] portaSrcPrev_q; // Previous Port A source levels
  logic [3:0] portcPrev_q; // Previous Port C levels
  logic [7:0] portaSrc; // Port A sources after shared mux
  logic [7:0] portaEdge; // Port A detected edges
  logic [3:0] portcEdge; // Port C detected edges
  // Bus decode
  logic busWr; // Write completes this edge
  logic busRd; // Read completes this edge
  logic [11:0] regIdx; // Register index from byte address
  logic addrOk; // Address maps to a register
  logic [7:0] rdVal; // Read mux
  logic [7:0] wrByte; // Low data byte
  // Arbitration
  logic anyWin; // Some enabled request pending
  logic [3:0] winId; // Winning source id
  logic [1:0] winLevel; // Winning level
  logic [1:0] events; // New events this cycle

  // Priority code of one source
  function automatic logic [1:0] levelOf(input logic hi, input logic lo);
    levelOf = {hi, lo};
  endfunction

  // Bus phases: no wait states
  assign busWr = psel && penable && pwrite;
  assign busRd = psel && penable && !pwrite;
  assign regIdx = paddr[13:2];
  assign wrByte = pwdata[7:0];

  // Address decode used for reads and error reply
  always_comb
  begin
    addrOk = 1'b1;
    rdVal = 8'h00;
    unique case (regIdx)
      PORTA_HIGH_IDX: rdVal = portaHigh_q;
      PORTA_LOW_IDX: rdVal = portaLow_q;
      PORTC_HIGH_IDX: rdVal = {4'h0, portcHigh_q};
      PORTC_LOW_IDX: rdVal = {4'h0, portcLow_q};
      EDGE_POL_IDX: rdVal = edgePol_q;
      SHARED_SEL_IDX: rdVal = sharedSel_q;
      PORTA_REQ_IDX: rdVal = portaReq_q;
      PORTC_REQ_IDX: rdVal = {4'h0, portcReq_q};
      GLOBAL_CTL_IDX: rdVal = {globalEn_q, 7'h00};
      IRQ_STATUS_IDX: rdVal = {6'h00, status_q};
      IRQ_MASK_IDX: rdVal = {6'h00, mask_q};
      default: addrOk = 1'b0;
    endcase
    if (paddr[31:14] != 18'h00000 || paddr[1:0] != 2'b00)
    begin
      addrOk = 1'b0;
      rdVal = 8'h00;
    end
  end

  // Shared source mux: pin 6 or comparator
  always_comb
  begin
    portaSrc = portaPins[7:0];
    if (sharedSel_q[SHARED_SEL_BIT])
    begin
      portaSrc[6] = comparatorOut;
    end
  end

  // Edge detect with per-pin polarity; source switch edges count too
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : gPortaEdge
      assign portaEdge[g] = edgePol_q[g] ? (portaSrc[g] && !portaSrcPrev_q[g])
                                         : (!portaSrc[g] && portaSrcPrev_q[g]);
    end
    for (g = 0; g < PORTC_WIDTH; g++)
    begin : gPortcEdge
      assign portcEdge[g] = edgePol_q[g] ? (portcPins[g] && !portcPrev_q[g])
                                         : (!portcPins[g] && portcPrev_q[g]);
    end
  endgenerate

  // Input history
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      portaSrcPrev_q <= 8'h00;
      portcPrev_q <= 4'h0;
    end
    else
    begin
      portaSrcPrev_q <= portaSrc;
      portcPrev_q <= portcPins;
    end
  end

  // Enable and configuration registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      portaHigh_q <= REG_RESET;
      portaLow_q <= REG_RESET;
      portcHigh_q <= REG_RESET[3:0];
      portcLow_q <= REG_RESET[3:0];
      edgePol_q <= REG_RESET;
      sharedSel_q <= REG_RESET;
      mask_q <= REG_RESET[1:0];
    end
    else if (busWr && addrOk)
    begin
      unique case (regIdx)
        PORTA_HIGH_IDX: portaHigh_q <= wrByte;
        PORTA_LOW_IDX: portaLow_q <= wrByte;
        PORTC_HIGH_IDX: portcHigh_q <= wrByte[3:0];
        PORTC_LOW_IDX: portcLow_q <= wrByte[3:0];
        EDGE_POL_IDX: edgePol_q <= wrByte;
        SHARED_SEL_IDX: sharedSel_q <= wrByte;
        IRQ_MASK_IDX: mask_q <= wrByte[1:0];
        default: ;
      endcase
    end
  end

  // Pending requests: edges set, bus write of zero clears, set wins
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      portaReq_q <= 8'h00;
      portcReq_q <= 4'h0;
    end
    else
    begin
      if (busWr && regIdx == PORTA_REQ_IDX && addrOk)
        portaReq_q <= wrByte | portaEdge;
      else
        portaReq_q <= portaReq_q | portaEdge;
      if (busWr && regIdx == PORTC_REQ_IDX && addrOk)
        portcReq_q <= wrByte[3:0] | portcEdge;
      else
        portcReq_q <= portcReq_q | portcEdge;
    end
  end

  // Global enable
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      globalEn_q <= 1'b0;
    else if (busWr && regIdx == GLOBAL_CTL_IDX && addrOk)
      globalEn_q <= wrByte[GLOBAL_EN_BIT];
  end

  // Fixed-order arbitration: higher level first, lower index on ties
  always_comb
  begin
    logic [1:0] lv; // Level of the source under test
    lv = PIPE_DISABLED;
    anyWin = 1'b0;
    winId = 4'h0;
    winLevel = PIPE_DISABLED;
    // Port A sources take ids 0 to 7
    for (int i = 0; i < 8; i++)
    begin
      lv = levelOf(portaHigh_q[i], portaLow_q[i]);
      if (portaReq_q[i] && lv != PIPE_DISABLED && lv > winLevel)
      begin
        anyWin = 1'b1;
        winId = 4'(i);
        winLevel = lv;
      end
    end
    // Port C sources follow as ids 8 to 11
    for (int i = 0; i < PORTC_WIDTH; i++)
    begin
      lv = levelOf(portcHigh_q[i], portcLow_q[i]);
      if (portcReq_q[i] && lv != PIPE_DISABLED && lv > winLevel)
      begin
        anyWin = 1'b1;
        winId = 4'(i + 8);
        winLevel = lv;
      end
    end
  end

  // Events: any new request edge, any forwarded request
  assign events = {anyWin && globalEn_q, (|portaEdge) | (|portcEdge)};

  // Sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      status_q <= 2'b00;
    else if (busWr && regIdx == IRQ_STATUS_IDX && addrOk)
      status_q <= (status_q & ~wrByte[1:0]) | events;
    else
      status_q <= status_q | events;
  end

  // CPU request outputs; only cpuReq is gated by global enable, id, level and irqOut are not
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cpuReq <= 1'b0;
      cpuReqId <= 4'h0;
      cpuReqLevel <= 2'b00;
      irqOut <= 1'b0;
    end
    else
    begin
      cpuReq <= anyWin && globalEn_q;
      cpuReqId <= winId;
      cpuReqLevel <= winLevel;
      irqOut <= |(status_q & mask_q);
    end
  end

  // Bus answer: ready in the access phase, data registered
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      prdata <= (psel && !penable && !pwrite) ? {24'h000000, rdVal} : 32'h00000000;
    end
  end

  property p_level_pair;
    @(posedge sys_clk) disable iff (!rstn)
      cpuReq && cpuReqId < 4'h8 |-> cpuReqLevel != 2'b00 &&
        cpuReqLevel == $past({portaHigh_q[winId[2:0]], portaLow_q[winId[2:0]]});
  endproperty
  a_level_pair: assert property (p_level_pair) else $error("Zero level forwarded");

  property p_portc_high;
    @(posedge sys_clk) disable iff (!rstn)
      busWr && addrOk && regIdx == PORTC_HIGH_IDX |=> portcHigh_q == $past(pwdata[3:0]);
  endproperty
  a_portc_high: assert property (p_portc_high) else $error("Port C high not written");

  property p_porta_high;
    @(posedge sys_clk) disable iff (!rstn)
      busWr && addrOk && regIdx == PORTA_HIGH_IDX |=> portaHigh_q == $past(wrByte);
  endproperty
  a_porta_high: assert property (p_porta_high) else $error("Port A high not written");

  property p_rise_sets;
    @(posedge sys_clk) disable iff (!rstn)
      edgePol_q[0] && !portaSrcPrev_q[0] && portaSrc[0] |=> portaReq_q[0];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("Rising edge lost");

  property p_pend;
    @(posedge sys_clk) disable iff (!rstn)
      |portcEdge |=> (portcReq_q & $past(portcEdge)) == $past(portcEdge);
  endproperty
  a_pend: assert property (p_pend) else $error("Pending bit not set");

  property p_global;
    @(posedge sys_clk) disable iff (!rstn)
      !globalEn_q |=> !cpuReq;
  endproperty
  a_global: assert property (p_global) else $error("Request without global enable");

  property p_select;
    @(posedge sys_clk) disable iff (!rstn)
      sharedSel_q[SHARED_SEL_BIT] |-> portaSrc[6] == comparatorOut;
  endproperty
  a_select: assert property (p_select) else $error("Shared mux wrong");

  property p_highest;
    @(posedge sys_clk) disable iff (!rstn)
      anyWin && globalEn_q && portaReq_q[0] && portaHigh_q[0] && portaLow_q[0]
        |=> cpuReq && cpuReqLevel == 2'b11;
  endproperty
  a_highest: assert property (p_highest) else $error("Top level not chosen");
endmodule

// ---- tb/pipe_cpu_model.sv ----
`timescale 1ns/10ps
// Behavioural CPU side: latches the request presented to it
module pipe_cpu_model
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic cpuReq,
  input wire logic [3:0] cpuReqId,
  input wire logic [1:0] cpuReqLevel,
  output logic [3:0] lastId,
  output logic [1:0] lastLevel
);
  import pipe_pkg::*;
  // Capture the winning source while a request stands
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lastId <= 4'h0;
      lastLevel <= 2'h0;
    end
    else if (cpuReq)
    begin
      lastId <= cpuReqId;
      lastLevel <= cpuReqLevel;
    end
  end
endmodule

// ---- tb/tb_pipe_top.sv ----
`timescale 1ns/10ps
// Bench for the port interrupt priority block
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %0t got %h expected %h", $time, a, e); end end
module tb_pipe_top;
  import pipe_pkg::*;
  logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr, comparatorOut, cpuReq, irqOut;
  logic [31:0] paddr, pwdata, prdata;
  logic [7:0] portaPins;
  logic [3:0] portcPins, cpuReqId, lastId;
  logic [1:0] cpuReqLevel, lastLevel;
  int errors, cmp_count, cyc;
  logic [31:0] rdat;
  logic serr;
  pipe_top dut (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portaPins(portaPins), .portcPins(portcPins),
    .comparatorOut(comparatorOut), .cpuReq(cpuReq), .cpuReqId(cpuReqId),
    .cpuReqLevel(cpuReqLevel), .irqOut(irqOut));
  pipe_cpu_model cpu (.sys_clk(sys_clk), .rstn(rstn), .cpuReq(cpuReq), .cpuReqId(cpuReqId),
    .cpuReqLevel(cpuReqLevel), .lastId(lastId), .lastLevel(lastLevel));
  // Byte address is the register index times four
  function automatic logic [31:0] adr(input logic [11:0] idx);
    return {18'h0, idx, 2'b00};
  endfunction
  // Clock at 20 MHz
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      give_verdict();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // One APB transfer: setup, then access until pready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait for the answer; only the hang guard ends a stuck wait
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    xfer(1'b1, adr(idx), d);
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [7:0] e);
    xfer(1'b0, adr(idx), 8'h00);
    `CHK(rdat, {24'h0, e})
  endtask
  // Drive Port A pins at a clock edge and let the edge settle
  task automatic pins(input logic [7:0] v);
    @(posedge sys_clk);
    portaPins <= v;
    tick(4);
  endtask
  initial
  begin
    errors = 0;
    cmp_count = 0;
    cyc = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    portaPins = 8'hff;
    portcPins = 4'h0;
    comparatorOut = 1'b0;
    tick(2);
    rstn <= 1'b1;
    // Reset values
    rdc(PORTA_HIGH_IDX, 8'h00);
    rdc(PORTA_LOW_IDX, 8'h00);
    rdc(PORTC_HIGH_IDX, 8'h00);
    rdc(PORTC_LOW_IDX, 8'h00);
    rdc(EDGE_POL_IDX, 8'h00);
    rdc(SHARED_SEL_IDX, 8'h00);
    wr(PORTA_HIGH_IDX, 8'ha5);
    wr(PORTA_LOW_IDX, 8'h3c);
    wr(PORTC_LOW_IDX, 8'h0f);
    rdc(PORTA_HIGH_IDX, 8'ha5);
    rdc(PORTA_LOW_IDX, 8'h3c);
    rdc(PORTC_LOW_IDX, 8'h0f);
    wr(PORTC_LOW_IDX, 8'h00);
    // Unmapped place is refused
    xfer(1'b0, 32'h0000_3f48, 8'h00);
    `CHK(serr, 1'b1)
    wr(GLOBAL_CTL_IDX, 8'h80);
    // Every priority code on pin 0, falling edge
    for (int lv = 0; lv < 4; lv++)
    begin
      wr(PORTA_HIGH_IDX, {7'h0, lv[1]});
      wr(PORTA_LOW_IDX, {7'h0, lv[0]});
      wr(PORTA_REQ_IDX, 8'h00);
      pins(8'hfe);
      `CHK(cpuReq, (lv != 0))
      if (lv != 0)
        `CHK({cpuReqId, cpuReqLevel}, {4'h0, lv[1:0]})
      rdc(PORTA_REQ_IDX, 8'h01);
      pins(8'hff);
    end
    // Level beats index; lower index wins a tie
    wr(PORTA_HIGH_IDX, 8'ha0);
    wr(PORTA_LOW_IDX, 8'ha4);
    wr(PORTA_REQ_IDX, 8'h00);
    pins(8'h5b);
    `CHK({lastId, lastLevel}, {4'h5, 2'h3})
    wr(GLOBAL_CTL_IDX, 8'h00);
    tick(3);
    `CHK(cpuReq, 1'b0)
    pins(8'hff);
    // Port C pin 1 at level 2 on a rising edge
    wr(PORTA_HIGH_IDX, 8'h00);
    wr(PORTA_LOW_IDX, 8'h00);
    wr(EDGE_POL_IDX, 8'h02);
    wr(PORTC_HIGH_IDX, 8'h02);
    rdc(PORTC_HIGH_IDX, 8'h02);
    wr(PORTC_REQ_IDX, 8'h00);
    wr(GLOBAL_CTL_IDX, 8'h80);
    portcPins <= 4'h2;
    tick(4);
    `CHK({cpuReqId, cpuReqLevel}, {4'h9, 2'h2})
    wr(PORTC_REQ_IDX, 8'h00);
    portcPins <= 4'h0;
    tick(4);
    rdc(PORTC_REQ_IDX, 8'h00);
    // Source switch to the low comparator makes a falling edge
    wr(EDGE_POL_IDX, 8'h00);
    wr(PORTA_REQ_IDX, 8'h00);
    wr(SHARED_SEL_IDX, 8'h40);
    tick(4);
    rdc(PORTA_REQ_IDX, 8'h40);
    wr(PORTA_REQ_IDX, 8'h00);
    pins(8'hbf);
    rdc(PORTA_REQ_IDX, 8'h00);
    comparatorOut <= 1'b1;
    tick(3);
    comparatorOut <= 1'b0;
    tick(4);
    rdc(PORTA_REQ_IDX, 8'h40);
    pins(8'hff);
    // Status, mask and level interrupt
    wr(IRQ_MASK_IDX, 8'h00);
    wr(IRQ_STATUS_IDX, 8'h03);
    pins(8'hfe);
    `CHK(irqOut, 1'b0)
    wr(IRQ_MASK_IDX, 8'h01);
    tick(2);
    `CHK(irqOut, 1'b1)
    wr(IRQ_STATUS_IDX, 8'h03);
    tick(2);
    `CHK(irqOut, 1'b0)
    give_verdict();
  end
endmodule
